// file: src/capture_defines.vh
`ifndef CAPTURE_DEFINES_VH
`define CAPTURE_DEFINES_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CON1      4'h0
`define ADDR_CON2      4'h4
`define ADDR_BUF       4'h8
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CON2_SYNC_RST  5'h0D
// ----------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------
`define C1_IDLE        13
`define C1_TB_HI       12
`define C1_TB_LO       10
`define C1_CPI_HI      6
`define C1_CPI_LO      5
`define C1_OV          4
`define C1_NE          3
`define C1_MODE_HI     2
`define C1_MODE_LO     0
// ----------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------
`define C2_CASC        8
`define C2_TRIG        7
`define C2_TSTAT       6
`define C2_SYNC_HI     4
`define C2_SYNC_LO     0
// ----------------------------------------------------------------
// Capture modes
// ----------------------------------------------------------------
`define MODE_OFF       3'h0
`define MODE_BOTH      3'h1
`define MODE_FALL      3'h2
`define MODE_RISE      3'h3
`define MODE_DIV4      3'h4
`define MODE_DIV16     3'h5
`define MODE_UNUSED    3'h6
`define MODE_WAKE      3'h7
// ----------------------------------------------------------------
// Timebase codes and misc counts
// ----------------------------------------------------------------
`define TB_SYSCLK      3'h7
`define TB_RSV_A       3'h6
`define TB_RSV_B       3'h5
`define SYNC_NONE      5'h00
`define DIV4_LAST      4'h3
`define DIV16_LAST     4'hF
`define FIFO_DEPTH     3'h4
`define CNT_MAX        16'hFFFF
`endif

// file: src/capture_channel.v
// Overview of operation
// - Mode 011 rising, 010 falling edge capture.
// - Mode 100 every 4th, 101 every 16th rise.
// - Mode 001 both edges; interrupt every capture.
// - Mode 111 rising-edge wake pin in Sleep/Idle.
// - Modes 000 and 110 disable the channel.
// - Interrupt after 1 to 4 captures.
// - Not-empty flag shows unread FIFO data.
// - Overflow flag shows a lost capture.
// - Idle-halt bit stops channel in Idle.
// - Timebase selector picks counting source.
// - Cascade bit joins pair into 32 bits.
// - Even module follows odd module synchronously.
// - Cascaded sync holds counter until source enabled.
// - Trigger bit: start trigger or counter sync.
// - Trigger status set by hardware; zero holds counter.
// - Sync selector maps codes to sources.
// - Capture writes 16-bit counter into FIFO.
// - FIFO holds four captured values.
// - Selector 00000 with trigger: software trigger.
`include "capture_defines.vh"

module capture_channel (
   input  wire        MCLK,
   input  wire        SYS_RST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [3:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire        CAPTURE_INPUT_PIN,
   input  wire [7:0]  TB_TICK,
   input  wire [31:0] SYNC_EVENT,
   input  wire [31:0] SYNC_SRC_ON,
   input  wire        CPU_IDLE,
   input  wire        CPU_SLEEP,
   input  wire        HIGH_HALF,
   input  wire        CAS_WRAP_IN,
   input  wire        CAS_CAP_IN,
   output reg         CAS_WRAP_OUT,
   output reg         CAS_CAP_OUT,
   output reg         CAPTURE_IRQ,
   output reg         WAKE_IRQ
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Picks the line of a 32-wide source vector named by a selector code.
   function pick;
      input [31:0] vec;
      input [4:0]  code;
      begin
         pick = vec[code];
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg        idle_halt_control_r;
   reg [2:0]  timebase_selector_r;
   reg [1:0]  captures_per_interrupt_r;
   reg [2:0]  capture_mode_selector_r;
   reg        capture_overflow_flag_r;
   reg        cascade_control_r;
   reg        trigger_select_bit_r;
   reg        trigger_status_bit_r;
   reg [4:0]  sync_source_selector_r;
   reg [15:0] counter_r;
   reg        pin_d_r;
   reg [3:0]  presc_r;
   reg [1:0]  irq_cnt_r;
   reg [15:0] fifo_mem [0:3];
   reg [1:0]  wr_ptr_r;
   reg [1:0]  rd_ptr_r;
   reg [2:0]  fill_r;

   wire       fifo_not_empty_flag = (fill_r != 3'h0);
   wire       fifo_full = (fill_r == `FIFO_DEPTH);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire       acc_done = PSEL & PENABLE & PREADY;
   wire       acc_wait = PSEL & PENABLE & ~PREADY;
   wire       hit_con1 = (PADDR == `ADDR_CON1);
   wire       hit_con2 = (PADDR == `ADDR_CON2);
   wire       hit_buf = (PADDR == `ADDR_BUF);
   wire       mapped = hit_con1 | hit_con2 | hit_buf;
   wire       wr_con1 = acc_done & PWRITE & hit_con1;
   wire       wr_con2 = acc_done & PWRITE & hit_con2;
   wire       pop = acc_done & ~PWRITE & hit_buf & fifo_not_empty_flag;

   wire [15:0] con1_view = {2'h0, idle_halt_control_r, timebase_selector_r, 3'h0,
                            captures_per_interrupt_r, capture_overflow_flag_r,
                            fifo_not_empty_flag, capture_mode_selector_r};
   wire [15:0] con2_view = {7'h00, cascade_control_r, trigger_select_bit_r,
                            trigger_status_bit_r, 1'b0, sync_source_selector_r};

   // ----------------------------------------------------------------
   // Operating conditions
   // ----------------------------------------------------------------
   // The even half of a cascade counts wraps of the odd half and copies its events.
   wire       even_casc = cascade_control_r & HIGH_HALF;
   wire       halted = idle_halt_control_r & CPU_IDLE;
   wire       mode_on = (capture_mode_selector_r != `MODE_OFF) &
                        (capture_mode_selector_r != `MODE_UNUSED) &
                        (capture_mode_selector_r != `MODE_WAKE);
   wire       run = mode_on & ~halted;
   // The even half always runs synchronously, whatever its trigger bit says.
   wire       trig_mode = trigger_select_bit_r & ~even_casc;
   wire       sync_hit = (sync_source_selector_r != `SYNC_NONE) &
                         pick(SYNC_EVENT, sync_source_selector_r);
   wire       src_on = pick(SYNC_SRC_ON, sync_source_selector_r);
   // A cascade in sync mode waits for its source to be switched on.
   wire       casc_hold = cascade_control_r & ~trig_mode &
                          (sync_source_selector_r != `SYNC_NONE) & ~src_on;
   wire       trig_hold = trig_mode & ~trigger_status_bit_r;
   wire       tb_tick = (timebase_selector_r == `TB_SYSCLK) ? 1'b1 :
                        ((timebase_selector_r == `TB_RSV_A) |
                         (timebase_selector_r == `TB_RSV_B)) ? 1'b0 :
                        TB_TICK[timebase_selector_r];
   wire       step = even_casc ? CAS_WRAP_IN : tb_tick;

   // ----------------------------------------------------------------
   // Edge detection and capture events
   // ----------------------------------------------------------------
   wire       rise = CAPTURE_INPUT_PIN & ~pin_d_r;
   wire       fall = ~CAPTURE_INPUT_PIN & pin_d_r;
   reg        edge_ev;
   reg        cap_ev;

   // Chooses which edges count as a capture for the current mode.
   always @* begin
      edge_ev = 1'b0;
      cap_ev = 1'b0;
      case (capture_mode_selector_r)
         `MODE_BOTH: edge_ev = rise | fall;
         `MODE_FALL: edge_ev = fall;
         `MODE_RISE: edge_ev = rise;
         `MODE_DIV4: edge_ev = rise & (presc_r == `DIV4_LAST);
         `MODE_DIV16: edge_ev = rise & (presc_r == `DIV16_LAST);
         default: edge_ev = 1'b0;
      endcase
      if (run) begin
         cap_ev = even_casc ? CAS_CAP_IN : edge_ev;
      end
   end

   // Interrupt fires on the n-th capture; both-edge mode fires on each one.
   wire       irq_due = (capture_mode_selector_r == `MODE_BOTH) |
                        (irq_cnt_r == captures_per_interrupt_r);

   // ----------------------------------------------------------------
   // Capture FIFO storage
   // ----------------------------------------------------------------
   // Each slot loads the counter when it is the write target of an accepted capture.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : slot
         always @(posedge MCLK) begin
            if (cap_ev & ~fifo_full & (wr_ptr_r == gi)) begin
               fifo_mem[gi] <= counter_r;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // FIFO pointers, fill level and overflow
   // ----------------------------------------------------------------
   // Turning the mode off empties the queue and clears overflow; a capture still wins.
   always @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_ptr_r <= 2'h0;
         rd_ptr_r <= 2'h0;
         fill_r <= 3'h0;
         capture_overflow_flag_r <= 1'b0;
      end else if (~mode_on & ~cap_ev) begin
         wr_ptr_r <= 2'h0;
         rd_ptr_r <= 2'h0;
         fill_r <= 3'h0;
         capture_overflow_flag_r <= 1'b0;
      end else begin
         if (cap_ev & ~fifo_full) begin
            wr_ptr_r <= wr_ptr_r + 2'h1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 2'h1;
         end
         if ((cap_ev & ~fifo_full) & ~pop) begin
            fill_r <= fill_r + 3'h1;
         end else if (~(cap_ev & ~fifo_full) & pop) begin
            fill_r <= fill_r - 3'h1;
         end
         if (cap_ev & fifo_full) begin
            capture_overflow_flag_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Counter, prescaler and edge history
   // ----------------------------------------------------------------
   // Counter clears when stopped, on a hold, or on a sync outside trigger mode; otherwise it steps on the timebase, or on partner wraps in an even half.
   always @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         counter_r <= 16'h0000;
         pin_d_r <= 1'b0;
         presc_r <= 4'h0;
         CAS_WRAP_OUT <= 1'b0;
         CAS_CAP_OUT <= 1'b0;
      end else begin
         pin_d_r <= CAPTURE_INPUT_PIN;
         CAS_CAP_OUT <= cap_ev;
         CAS_WRAP_OUT <= 1'b0;
         if (~run | casc_hold | trig_hold) begin
            counter_r <= 16'h0000;
         end else if (sync_hit & ~trig_mode) begin
            counter_r <= 16'h0000;
         end else if (step) begin
            counter_r <= counter_r + 16'h0001;
            CAS_WRAP_OUT <= (counter_r == `CNT_MAX);
         end
         if (~run) begin
            presc_r <= 4'h0;
         end else if (rise) begin
            presc_r <= (capture_mode_selector_r == `MODE_DIV4 && presc_r == `DIV4_LAST) ?
                       4'h0 : presc_r + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers and trigger status
   // ----------------------------------------------------------------
   // Software writes the fields; a hardware trigger sets the status and beats a clear.
   always @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         idle_halt_control_r <= 1'b0;
         timebase_selector_r <= 3'h0;
         captures_per_interrupt_r <= 2'h0;
         capture_mode_selector_r <= `MODE_OFF;
         cascade_control_r <= 1'b0;
         trigger_select_bit_r <= 1'b0;
         trigger_status_bit_r <= 1'b0;
         sync_source_selector_r <= `CON2_SYNC_RST;
      end else begin
         if (wr_con1) begin
            idle_halt_control_r <= PWDATA[`C1_IDLE];
            timebase_selector_r <= PWDATA[`C1_TB_HI:`C1_TB_LO];
            captures_per_interrupt_r <= PWDATA[`C1_CPI_HI:`C1_CPI_LO];
            capture_mode_selector_r <= PWDATA[`C1_MODE_HI:`C1_MODE_LO];
         end
         if (wr_con2) begin
            cascade_control_r <= PWDATA[`C2_CASC];
            trigger_select_bit_r <= PWDATA[`C2_TRIG];
            sync_source_selector_r <= PWDATA[`C2_SYNC_HI:`C2_SYNC_LO];
         end
         if (trig_mode & sync_hit & run) begin
            trigger_status_bit_r <= 1'b1;
         end else if (wr_con2) begin
            trigger_status_bit_r <= PWDATA[`C2_TSTAT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   // Counts captures toward the interrupt and drives the one-cycle pulses.
   always @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_cnt_r <= 2'h0;
         CAPTURE_IRQ <= 1'b0;
         WAKE_IRQ <= 1'b0;
      end else begin
         CAPTURE_IRQ <= 1'b0;
         WAKE_IRQ <= (capture_mode_selector_r == `MODE_WAKE) & rise &
                     (CPU_IDLE | CPU_SLEEP);
         if (~run) begin
            irq_cnt_r <= 2'h0;
         end else if (cap_ev) begin
            if (irq_due) begin
               irq_cnt_r <= 2'h0;
               CAPTURE_IRQ <= 1'b1;
            end else begin
               irq_cnt_r <= irq_cnt_r + 2'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // One wait state; read data and error are loaded on the same edge that raises ready.
   always @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= acc_wait;
         PSLVERR <= acc_wait & ~mapped;
         if (acc_wait & ~PWRITE) begin
            if (hit_con1) begin
               PRDATA <= {16'h0000, con1_view};
            end else if (hit_con2) begin
               PRDATA <= {16'h0000, con2_view};
            end else if (hit_buf) begin
               PRDATA <= {16'h0000, fifo_mem[rd_ptr_r]};
            end else begin
               PRDATA <= 32'h00000000;
            end
         end
      end
   end

endmodule // capture_channel

// file: verif/capture_channel_properties.sv
// ----------------------------------------------------------------
// Port checker for one capture channel
// ----------------------------------------------------------------
module capture_channel_properties (
   input wire logic        MCLK,
   input wire logic        SYS_RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        CAPTURE_INPUT_PIN,
   input wire logic        CPU_IDLE,
   input wire logic        CPU_SLEEP,
   input wire logic        CAS_CAP_OUT,
   input wire logic        CAPTURE_IRQ,
   input wire logic        WAKE_IRQ,
   input wire logic        HIGH_HALF,
   input wire logic        CAS_CAP_IN
);
   timeunit 1ns;
   timeprecision 1ns;
   // All checks share the one clock and stay quiet during reset.
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   // An access phase still waiting, and a pin level change one cycle back.
   sequence s_access; PSEL && PENABLE && !PREADY; endsequence
   sequence s_pin_edge; $past(CAPTURE_INPUT_PIN) != $past(CAPTURE_INPUT_PIN, 2); endsequence
   property p_ready_next; s_access |=> PREADY; endproperty
   property p_ready_cause; PREADY |-> $past(PSEL && PENABLE && !PREADY); endproperty
   property p_ready_pulse; PREADY |=> !PREADY; endproperty
   property p_err_ready; PSLVERR |-> PREADY; endproperty
   property p_rdata_hold; !$stable(PRDATA) |-> PREADY && !PWRITE; endproperty
   property p_rdata_upper; PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000; endproperty
   property p_cap_edge; CAS_CAP_OUT && !HIGH_HALF |-> s_pin_edge; endproperty
   property p_cap_casc; CAS_CAP_OUT && HIGH_HALF &&
      $past(CAPTURE_INPUT_PIN) == $past(CAPTURE_INPUT_PIN, 2) |-> $past(CAS_CAP_IN); endproperty
   property p_irq_cap; CAPTURE_IRQ |-> CAS_CAP_OUT; endproperty
   property p_wake; WAKE_IRQ |-> $past(CPU_SLEEP || CPU_IDLE) && $past(CAPTURE_INPUT_PIN)
      && !$past(CAPTURE_INPUT_PIN, 2); endproperty
   property p_wake_nocap; WAKE_IRQ |-> !CAS_CAP_OUT; endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("ready missing after access");
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without access");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed outside a read");
   a_rdata_upper: assert property (p_rdata_upper)
      else $error("upper read half not zero");
   a_cap_edge: assert property (p_cap_edge)
      else $error("capture without pin edge");
   a_cap_casc: assert property (p_cap_casc)
      else $error("even half captured without partner capture");
   a_irq_cap: assert property (p_irq_cap)
      else $error("interrupt without capture");
   a_wake: assert property (p_wake)
      else $error("wake without rise in low power");
   a_wake_nocap: assert property (p_wake_nocap)
      else $error("wake mode stored a capture");
endmodule // capture_channel_properties

// file: verif/pulse_source.sv
// ----------------------------------------------------------------
// Far side: capture pin, timebase ticks and sync sources
// ----------------------------------------------------------------
module pulse_source (
   input  wire logic        clk,
   output logic             pin,
   output logic [7:0]       tick,
   output logic [31:0]      sync_event,
   output logic [31:0]      src_on
);
   timeunit 1ns;
   timeprecision 1ns;
   logic phase_r = 1'b0;
   // Timers tick every other cycle, reserved codes never, system clock always.
   always @(posedge clk) phase_r <= ~phase_r;
   assign tick = {1'b1, 2'b00, {5{phase_r}}};
   // All sources stay enabled; the pin idles low.
   initial begin
      pin = 1'b0;
      sync_event = 32'h0000_0000;
      src_on = 32'hFFFF_FFFF;
   end
   // Pulses rise every six cycles and stay high for three.
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         pin <= 1'b1;
         repeat (3) @(posedge clk);
         pin <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   // One-cycle event from another source, never this channel.
   task automatic sync_pulse(input int idx);
      @(posedge clk);
      sync_event[idx] <= 1'b1;
      @(posedge clk);
      sync_event <= 32'h0000_0000;
   endtask
endmodule // pulse_source

// file: verif/input_capture_dedicated_timer_bench.sv
`include "capture_defines.vh"
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module input_capture_dedicated_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [15:0] con1; logic [1:0] pwr; int n; int caps; int irqs; int wakes;} row_t;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [3:0]  paddr = 4'h0;
   logic [31:0] pwdata = 32'h0;
   logic        cpu_idle = 1'b0;
   logic        cpu_sleep = 1'b0;
   logic [31:0] prdata, rd, v1, sync_event, src_on;
   logic        pready, pslverr, cap_irq, wake_irq, err, pin, cas_cap_out;
   logic        high_half = 1'b0;
   logic        cas_wrap = 1'b0;
   logic        cas_cap = 1'b0;
   logic [7:0]  tick;
   int          errors = 0, compares = 0, nirq = 0, nwake = 0, cycles = 0, pops = 0, ncap = 0;
   row_t rows[11] = '{'{16'h1C63, 0, 4, 4, 1, 0}, '{16'h1C22, 0, 3, 3, 1, 0},
      '{16'h1C61, 0, 2, 4, 4, 0}, '{16'h1C04, 0, 8, 2, 2, 0}, '{16'h1C05, 0, 16, 1, 1, 0},
      '{16'h1C43, 0, 3, 3, 1, 0}, '{16'h1C06, 0, 2, 0, 0, 0}, '{16'h1C00, 0, 2, 0, 0, 0},
      '{16'h3C03, 1, 2, 0, 0, 0}, '{16'h1C03, 1, 2, 2, 2, 0}, '{16'h1C07, 2, 2, 0, 0, 2}};
   always #20 mclk = ~mclk;
   capture_channel i_dut (
      .MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CAPTURE_INPUT_PIN(pin), .TB_TICK(tick), .SYNC_EVENT(sync_event),
      .SYNC_SRC_ON(src_on), .CPU_IDLE(cpu_idle), .CPU_SLEEP(cpu_sleep), .HIGH_HALF(high_half),
      .CAS_WRAP_IN(cas_wrap), .CAS_CAP_IN(cas_cap), .CAS_WRAP_OUT(), .CAS_CAP_OUT(cas_cap_out),
      .CAPTURE_IRQ(cap_irq), .WAKE_IRQ(wake_irq));
   pulse_source i_src (.clk(mclk), .pin(pin), .tick(tick), .sync_event(sync_event),
      .src_on(src_on));
   // Counts interrupt pulses and cuts a hung run short.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cap_irq === 1'b1) nirq <= nirq + 1;
      if (wake_irq === 1'b1) nwake <= nwake + 1;
      if (cas_cap_out === 1'b1) ncap <= ncap + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         end_of_test();
      end
   end
   // One APB transfer; holds the request until ready is sampled high.
   task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Reads the buffer until empty; leaves the last control one read in rd.
   task automatic drain();
      pops = 0;
      apb(1'b0, `ADDR_CON1, 32'h0);
      while (rd[3] === 1'b1 && pops < 8) begin
         apb(1'b0, `ADDR_BUF, 32'h0);
         pops++;
         apb(1'b0, `ADDR_CON1, 32'h0);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Main sequence: reset, table of modes, then overflow and trigger cases.
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      apb(1'b0, `ADDR_CON1, 32'h0);
      chk("con1 reset", rd, 32'h0000_0000);
      apb(1'b0, `ADDR_CON2, 32'h0);
      chk("con2 reset", rd, 32'h0000_000D);
      apb(1'b0, 4'hC, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      apb(1'b1, `ADDR_CON1, 32'h0000_0018);
      apb(1'b0, `ADDR_CON1, 32'h0);
      chk("flags read only", rd, 32'h0000_0000);
      $display("reset test done");
      foreach (rows[i]) begin
         {cpu_sleep, cpu_idle} <= rows[i].pwr;
         nirq = 0;
         nwake = 0;
         ncap = 0;
         apb(1'b1, `ADDR_CON1, {16'h0, rows[i].con1});
         i_src.pulses(rows[i].n);
         repeat (4) @(posedge mclk);
         apb(1'b0, `ADDR_CON1, 32'h0);
         chk("not empty", rd[3], rows[i].caps != 0);
         chk("overflow", rd[4], 32'h0);
         drain();
         chk("captures", pops, rows[i].caps);
         chk("irqs", nirq, rows[i].irqs);
         chk("wakes", nwake, rows[i].wakes);
         chk("capture pulses", ncap, rows[i].caps);
         apb(1'b1, `ADDR_CON1, 32'h0);
         $display("row %0d done", i);
      end
      {cpu_sleep, cpu_idle} <= 2'b00;
      apb(1'b1, `ADDR_CON1, 32'h0000_1C03);
      i_src.pulses(5);
      apb(1'b0, `ADDR_CON1, 32'h0);
      chk("full flags", rd, 32'h0000_1C1B);
      apb(1'b0, `ADDR_BUF, 32'h0);
      v1 = rd;
      apb(1'b0, `ADDR_BUF, 32'h0);
      chk("capture spacing", rd - v1, 32'h6);
      drain();
      chk("fifo depth", pops + 2, 32'h4);
      chk("overflow kept", rd, 32'h0000_1C13);
      sys_rst <= 1'b1;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      apb(1'b0, `ADDR_CON1, 32'h0);
      chk("con1 after reset", rd, 32'h0000_0000);
      $display("overflow test done");
      apb(1'b1, `ADDR_CON1, 32'h0000_1C03);
      apb(1'b1, `ADDR_CON2, 32'h0000_008D);
      i_src.sync_pulse(13);
      apb(1'b0, `ADDR_CON2, 32'h0);
      chk("hw trigger status", rd, 32'h0000_00CD);
      apb(1'b1, `ADDR_CON2, 32'h0000_0080);
      apb(1'b1, `ADDR_CON1, 32'h0000_1C03);
      i_src.pulses(1);
      apb(1'b0, `ADDR_BUF, 32'h0);
      chk("held clear", rd, 32'h0000_0000);
      apb(1'b1, `ADDR_CON2, 32'h0000_00C0);
      i_src.pulses(2);
      apb(1'b0, `ADDR_BUF, 32'h0);
      v1 = rd;
      apb(1'b0, `ADDR_BUF, 32'h0);
      chk("sw trigger run", rd - v1, 32'h6);
      $display("trigger test done");
      // Even half of a cascade: counts partner wraps, copies partner captures.
      high_half <= 1'b1;
      apb(1'b1, `ADDR_CON1, 32'h0);
      apb(1'b1, `ADDR_CON2, 32'h0000_0180);
      apb(1'b1, `ADDR_CON1, 32'h0000_1C03);
      repeat (3) begin
         @(posedge mclk);
         cas_wrap <= 1'b1;
         @(posedge mclk);
         cas_wrap <= 1'b0;
      end
      @(posedge mclk);
      cas_cap <= 1'b1;
      @(posedge mclk);
      cas_cap <= 1'b0;
      apb(1'b0, `ADDR_BUF, 32'h0);
      chk("high word", rd, 32'h0000_0003);
      i_src.pulses(1);
      apb(1'b0, `ADDR_CON1, 32'h0);
      chk("even ignores pin", rd, 32'h0000_1C03);
      // Sync mode: a source event restarts the counter.
      high_half <= 1'b0;
      apb(1'b1, `ADDR_CON2, 32'h0000_000D);
      i_src.sync_pulse(13);
      i_src.pulses(1);
      apb(1'b0, `ADDR_BUF, 32'h0);
      chk("sync restart", rd, 32'h0000_0001);
      $display("cascade test done");
      end_of_test();
   end
endmodule // input_capture_dedicated_timer_bench

bind capture_channel capture_channel_properties i_props (
   .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CAPTURE_INPUT_PIN(CAPTURE_INPUT_PIN), .CPU_IDLE(CPU_IDLE), .CPU_SLEEP(CPU_SLEEP),
   .CAS_CAP_OUT(CAS_CAP_OUT), .CAPTURE_IRQ(CAPTURE_IRQ), .WAKE_IRQ(WAKE_IRQ),
   .HIGH_HALF(HIGH_HALF), .CAS_CAP_IN(CAS_CAP_IN));
